//--- core/dpc_pkg.sv
/*
 * Shared constants and types for the sample-clock synthesizer start-up block:
 * register addresses, field positions, reset values, timing counts and carriers.
 * Assumes a single 125 MHz clock domain and 11-bit configuration addresses.
 */
package dpc_pkg;

    // Register port geometry.
    localparam int ADDR_W     = 11;
    localparam int DATA_W     = 8;
    localparam int MEM_DEPTH  = 2048;
    localparam int SAMPLE_W   = 16;

    // Register addresses.
    localparam logic [10:0] A_SPI_CFG    = 11'h000;
    localparam logic [10:0] A_POWER      = 11'h011;
    localparam logic [10:0] A_IRQ_EN     = 11'h01f;
    localparam logic [10:0] A_IRQ_STAT   = 11'h023;
    localparam logic [10:0] A_GAIN_I_HI  = 11'h040;
    localparam logic [10:0] A_GAIN_I_LO  = 11'h041;
    localparam logic [10:0] A_GAIN_Q_HI  = 11'h042;
    localparam logic [10:0] A_GAIN_Q_LO  = 11'h043;
    localparam logic [10:0] A_PLL_CTL    = 11'h083;
    localparam logic [10:0] A_PLL_STAT   = 11'h084;
    localparam logic [10:0] A_LOOP_CNT   = 11'h085;
    localparam logic [10:0] A_VCO_DIV    = 11'h08b;
    localparam logic [10:0] A_REF_DIV    = 11'h08c;
    localparam logic [10:0] A_DATA_FMT   = 11'h110;
    localparam logic [10:0] A_TEMP_EN    = 11'h12f;
    localparam logic [10:0] A_TEMP_LO    = 11'h132;
    localparam logic [10:0] A_TEMP_HI    = 11'h133;
    localparam logic [10:0] A_TEMP_TRIG  = 11'h134;

    // Field positions.
    localparam int PLL_EN_BIT    = 4;
    localparam int PLL_RECAL_BIT = 7;
    localparam int ST_UPPER_BIT  = 7;
    localparam int ST_LOWER_BIT  = 6;
    localparam int ST_CALOK_BIT  = 5;
    localparam int ST_LOCK_BIT   = 1;
    localparam int FMT_BIN_BIT   = 0;
    localparam int TEMP_BIT      = 0;

    // Command codes, masks, limits and values after reset.
    localparam logic [7:0]  SOFT_RST_CODE  = 8'hbd;
    localparam logic [7:0]  SOFT_REL_CODE  = 8'h3c;
    localparam logic [7:0]  FOUR_WIRE_MASK = 8'h18;
    localparam logic [7:0]  SPI_CFG_RST    = 8'h00;
    localparam logic [7:0]  POWER_RST      = 8'hff;
    localparam logic [9:0]  GAIN_RST       = 10'h3ff;
    localparam logic [7:0]  LOOP_CNT_RST   = 8'h10;
    localparam logic [7:0]  LOOP_CNT_MIN   = 8'h06;
    localparam logic [7:0]  LOOP_CNT_MAX   = 8'h7f;
    localparam logic [1:0]  VCO_DIV_RST    = 2'h2;
    localparam logic [2:0]  REF_DIV_RST    = 3'h3;
    localparam logic [15:0] SIGN_FLIP      = 16'h8000;

    // Band calibration length in clock cycles.
    localparam logic [15:0] CAL_CYCLES     = 16'h00c8;

    // One register access as delivered by the serial configuration port.
    typedef struct packed {
        logic [10:0] addr;
        logic [7:0]  wdata;
        logic        wr;
        logic        rd;
    } dpc_reg_req_t;

    // Settings handed to the synthesizer core.
    typedef struct packed {
        logic       enable;
        logic [1:0] vco_output_divider_select;
        logic [7:0] feedback_loop_divide_count;
        logic [2:0] reference_divider_select;
    } dpc_synth_cfg_t;

    // Band calibration progress.
    typedef enum logic [1:0] {
        CAL_OFF,
        CAL_RUN,
        CAL_DONE
    } dpc_cal_t;

endpackage : dpc_pkg

//--- core/dpc_cfg_mem.sv
/*
 * Byte store for the plain configuration registers that only hold a value.
 * Assumes one clock; read data appear from a register one cycle after rd_en.
 */
`timescale 1ns/1ps
module dpc_cfg_mem
    import dpc_pkg::*;
(
    // Clock.
    input  wire logic              clk,
    // Write side.
    input  wire logic              wr_en,
    input  wire logic [10:0]       addr,
    input  wire logic [7:0]        wdata,
    // Read side.
    input  wire logic              rd_en,
    output logic      [7:0]        rdata
);

    logic [7:0] mem [MEM_DEPTH];

    // Write and registered read share the single address.
    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem[addr] <= wdata;
        end
        if (rd_en) begin
            rdata <= mem[addr];
        end
    end

endmodule : dpc_cfg_mem

//--- core/dpc_pll_ctrl.sv
/*
 * Start-up and monitoring logic of the sample-clock synthesizer, gain codes,
 * input code format and temperature sensing, behind the configuration port.
 * Assumes register accesses arrive already deserialized, one per cycle,
 * and that all analog status inputs are synchronous to clk.
 */
// Functional notes
// - VCO output divider select lives in bits 1:0 of register 0x08B.
// - Loop divide count uses all eight bits of register 0x085.
// - Reference divider select lives in bits 2:0 of register 0x08C.
// - Status bit 5 of 0x084 shows calibration completed and valid.
// - Status bit 1 of 0x084 is high while the synthesizer is locked.
// - Status bits 7 and 6 flag upper and lower band edge reached.
// - Writing recalibrate bit 0 then 1 in 0x083 restarts calibration.
// - Lock and lock-lost events interrupt only when enabled in 0x01F.
// - Register 0x023 bits 7:6 show and clear those interrupt events.
// - Twos complement input is offset by half scale; binary passes through.
// - Temperature sensor stays off until 0x12F bit 0 is set.
// - Writing 0 then 1 to 0x134 bit 0 takes a temperature sample.
// - Writing 0xBD to 0x000 holds soft reset; 0x3C releases, four-wire.
// - Writing 0x00 to 0x011 powers reference, channels and clocks up.
// - Loop divide count only takes values from 6 through 127.
`timescale 1ns/1ps
module dpc_pll_ctrl
    import dpc_pkg::*;
(
    // Clock and reset.
    input  wire logic              clk,
    input  wire logic              srst,
    // Configuration port.
    input  wire dpc_reg_req_t      reg_req,
    output logic      [7:0]        reg_rdata,
    output logic                   reg_rvalid,
    // Synthesizer core.
    output dpc_synth_cfg_t         synth_cfg,
    output logic                   cal_start,
    input  wire logic              pll_lock_detect,
    input  wire logic              band_upper_hit,
    input  wire logic              band_lower_hit,
    output logic                   irq,
    // Power, port mode and gain.
    output logic      [7:0]        power_down,
    output logic                   four_wire_mode,
    output logic                   soft_reset_active,
    output logic      [9:0]        inphase_fullscale_gain,
    output logic      [9:0]        quadrature_fullscale_gain,
    // Temperature sensor.
    output logic                   temp_sensor_enable,
    output logic                   temp_sample_req,
    input  wire logic [15:0]       temp_result,
    input  wire logic              temp_result_valid,
    // Sample datapath.
    input  wire logic [15:0]       sample_in,
    input  wire logic              sample_valid,
    output logic      [15:0]       code_out,
    output logic                   code_valid
);

    // Whole state of the block.
    typedef struct packed {
        logic        soft_rst;
        logic [7:0]  spi_cfg;
        logic [7:0]  pwr_dn;
        logic [1:0]  irq_en;
        logic [1:0]  irq_stat;
        logic [9:0]  gain_i;
        logic [9:0]  gain_q;
        logic [7:0]  pll_ctl;
        logic [1:0]  vco_div;
        logic [7:0]  loop_cnt;
        logic [2:0]  ref_div;
        logic        band_hi;
        logic        band_lo;
        dpc_cal_t    cal;
        logic [15:0] cal_cnt;
        logic        cal_start;
        logic        lock_q;
        logic        fmt_bin;
        logic        temp_en;
        logic        temp_trig;
        logic        temp_req;
        logic [15:0] temp_code;
        logic [7:0]  rdata;
        logic        rvalid;
        logic        rd_mem;
        logic [15:0] code;
        logic        code_valid;
    } dpc_state_t;

    localparam dpc_state_t ST_RST = '{
        soft_rst: 1'b0, spi_cfg: SPI_CFG_RST, pwr_dn: POWER_RST, irq_en: 2'h0,
        irq_stat: 2'h0, gain_i: GAIN_RST, gain_q: GAIN_RST, pll_ctl: 8'h00,
        vco_div: VCO_DIV_RST, loop_cnt: LOOP_CNT_RST, ref_div: REF_DIV_RST,
        band_hi: 1'b0, band_lo: 1'b0, cal: CAL_OFF, cal_cnt: 16'h0000,
        cal_start: 1'b0, lock_q: 1'b0, fmt_bin: 1'b0, temp_en: 1'b0,
        temp_trig: 1'b0, temp_req: 1'b0, temp_code: 16'h0000, rdata: 8'h00,
        rvalid: 1'b0, rd_mem: 1'b0, code: 16'h0000, code_valid: 1'b0
    };

    dpc_state_t state_reg;
    dpc_state_t state_next;
    logic [7:0] mem_rdata;
    logic       mem_wr;
    logic       mem_rd;

    // True for addresses decoded by this block rather than the byte store.
    function automatic logic is_local(input logic [10:0] a);
        is_local = (a == A_SPI_CFG)   || (a == A_POWER)     || (a == A_IRQ_EN)
                || (a == A_IRQ_STAT)  || (a == A_GAIN_I_HI) || (a == A_GAIN_I_LO)
                || (a == A_GAIN_Q_HI) || (a == A_GAIN_Q_LO) || (a == A_PLL_CTL)
                || (a == A_PLL_STAT)  || (a == A_LOOP_CNT)  || (a == A_VCO_DIV)
                || (a == A_REF_DIV)   || (a == A_DATA_FMT)  || (a == A_TEMP_EN)
                || (a == A_TEMP_LO)   || (a == A_TEMP_HI)   || (a == A_TEMP_TRIG);
    endfunction : is_local

    // Detects a 0 to 1 step of one control bit caused by a write.
    function automatic logic bit_rise(input logic [7:0] old_v, input logic [7:0] new_v,
                                      input int idx);
        bit_rise = !old_v[idx] && new_v[idx];
    endfunction : bit_rise

    // Read value of a locally decoded register.
    function automatic logic [7:0] read_local(input dpc_state_t s, input logic [10:0] a);
        logic [7:0] v;
        v = 8'h00;
        unique case (a)
            A_SPI_CFG:   v = s.spi_cfg;
            A_POWER:     v = s.pwr_dn;
            A_IRQ_EN:    v = {s.irq_en, 6'h00};
            A_IRQ_STAT:  v = {s.irq_stat, 6'h00};
            A_GAIN_I_HI: v = {6'h00, s.gain_i[9:8]};
            A_GAIN_I_LO: v = s.gain_i[7:0];
            A_GAIN_Q_HI: v = {6'h00, s.gain_q[9:8]};
            A_GAIN_Q_LO: v = s.gain_q[7:0];
            A_PLL_CTL:   v = s.pll_ctl;
            A_PLL_STAT:  v = {s.band_hi, s.band_lo, s.cal == CAL_DONE, 3'h0, s.lock_q, 1'b0};
            A_LOOP_CNT:  v = s.loop_cnt;
            A_VCO_DIV:   v = {6'h00, s.vco_div};
            A_REF_DIV:   v = {5'h00, s.ref_div};
            A_DATA_FMT:  v = {7'h00, s.fmt_bin};
            A_TEMP_EN:   v = {7'h00, s.temp_en};
            A_TEMP_LO:   v = s.temp_code[7:0];
            A_TEMP_HI:   v = s.temp_code[15:8];
            A_TEMP_TRIG: v = {7'h00, s.temp_trig};
            default:     v = 8'h00;
        endcase
        read_local = v;
    endfunction : read_local

    // Keeps the loop divide count inside its legal range.
    function automatic logic [7:0] clamp_count(input logic [7:0] c);
        if (c < LOOP_CNT_MIN) begin
            clamp_count = LOOP_CNT_MIN;
        end else if (c > LOOP_CNT_MAX) begin
            clamp_count = LOOP_CNT_MAX;
        end else begin
            clamp_count = c;
        end
    endfunction : clamp_count

    logic       wr;
    logic       lw;
    logic       en_rise;
    logic       recal;
    logic [10:0] wa;
    logic [7:0] wd;
    logic [7:0] keep_spi;

    // Next-state logic of the whole block.
    always_comb begin
        state_next = state_reg;
        wr = reg_req.wr;
        wa = reg_req.addr;
        wd = reg_req.wdata;
        keep_spi = 8'h00;
        state_next.cal_start = 1'b0;
        state_next.temp_req = 1'b0;
        state_next.rvalid = reg_req.rd;
        state_next.rd_mem = reg_req.rd && !is_local(reg_req.addr);
        if (reg_req.rd) begin
            state_next.rdata = read_local(state_reg, reg_req.addr);
        end

        if (wr && wa == A_SPI_CFG) begin
            state_next.spi_cfg = wd;
            if (wd == SOFT_RST_CODE) begin
                state_next.soft_rst = 1'b1;
            end else if (wd == SOFT_REL_CODE) begin
                state_next.soft_rst = 1'b0;
            end
        end

        // Other registers take writes only outside soft reset.
        lw = wr && !state_reg.soft_rst;
        en_rise = lw && wa == A_PLL_CTL && bit_rise(state_reg.pll_ctl, wd, PLL_EN_BIT);
        recal = lw && wa == A_PLL_CTL && wd[PLL_EN_BIT]
                && bit_rise(state_reg.pll_ctl, wd, PLL_RECAL_BIT);
        if (lw) begin
            case (wa)
                A_POWER:     state_next.pwr_dn = wd;
                A_IRQ_EN:    state_next.irq_en = wd[7:6];
                A_GAIN_I_HI: state_next.gain_i[9:8] = wd[1:0];
                A_GAIN_I_LO: state_next.gain_i[7:0] = wd;
                A_GAIN_Q_HI: state_next.gain_q[9:8] = wd[1:0];
                A_GAIN_Q_LO: state_next.gain_q[7:0] = wd;
                A_PLL_CTL:   state_next.pll_ctl = wd;
                A_LOOP_CNT:  state_next.loop_cnt = wd;
                A_VCO_DIV:   state_next.vco_div = wd[1:0];
                A_REF_DIV:   state_next.ref_div = wd[2:0];
                A_DATA_FMT:  state_next.fmt_bin = wd[FMT_BIN_BIT];
                A_TEMP_EN:   state_next.temp_en = wd[TEMP_BIT];
                A_TEMP_TRIG: state_next.temp_trig = wd[TEMP_BIT];
                default:     state_next.pwr_dn = state_next.pwr_dn;
            endcase
        end

        unique case (state_reg.cal)
            CAL_OFF:  state_next.cal = CAL_OFF;
            CAL_RUN: begin
                if (state_reg.cal_cnt == 16'h0000) begin
                    state_next.cal = CAL_DONE;
                end else begin
                    state_next.cal_cnt = state_reg.cal_cnt - 16'h0001;
                end
            end
            CAL_DONE: state_next.cal = CAL_DONE;
        endcase
        if (en_rise || recal) begin
            state_next.cal = CAL_RUN;
            state_next.cal_cnt = CAL_CYCLES - 16'h0001;
            state_next.cal_start = 1'b1;
            state_next.band_hi = 1'b0;
            state_next.band_lo = 1'b0;
        end
        if (!state_next.pll_ctl[PLL_EN_BIT]) begin
            state_next.cal = CAL_OFF;
        end

        if (state_reg.pll_ctl[PLL_EN_BIT] && band_upper_hit) begin
            state_next.band_hi = 1'b1;
        end
        if (state_reg.pll_ctl[PLL_EN_BIT] && band_lower_hit) begin
            state_next.band_lo = 1'b1;
        end

        state_next.lock_q = (state_next.cal == CAL_DONE) && pll_lock_detect;

        if (lw && wa == A_IRQ_STAT) begin
            state_next.irq_stat = state_reg.irq_stat & ~wd[7:6];
        end
        if (state_next.lock_q && !state_reg.lock_q && state_reg.irq_en[1]) begin
            state_next.irq_stat[1] = 1'b1;
        end
        if (!state_next.lock_q && state_reg.lock_q && state_reg.irq_en[0]) begin
            state_next.irq_stat[0] = 1'b1;
        end

        if (lw && wa == A_TEMP_TRIG && state_reg.temp_en
                && bit_rise({7'h00, state_reg.temp_trig}, wd, TEMP_BIT)) begin
            state_next.temp_req = 1'b1;
        end
        if (temp_result_valid && state_reg.temp_en) begin
            state_next.temp_code = temp_result;
        end

        state_next.code_valid = sample_valid;
        if (sample_valid) begin
            state_next.code = state_reg.fmt_bin ? sample_in : (sample_in ^ SIGN_FLIP);
        end

        // Soft reset returns every state field but the port setup and the read response to reset values.
        if (state_next.soft_rst) begin
            keep_spi = state_next.spi_cfg;
            state_next = '{
                soft_rst: 1'b1, spi_cfg: keep_spi, pwr_dn: POWER_RST, irq_en: 2'h0,
                irq_stat: 2'h0, gain_i: GAIN_RST, gain_q: GAIN_RST, pll_ctl: 8'h00,
                vco_div: VCO_DIV_RST, loop_cnt: LOOP_CNT_RST, ref_div: REF_DIV_RST,
                band_hi: 1'b0, band_lo: 1'b0, cal: CAL_OFF, cal_cnt: 16'h0000,
                cal_start: 1'b0, lock_q: 1'b0, fmt_bin: 1'b0, temp_en: 1'b0,
                temp_trig: 1'b0, temp_req: 1'b0, temp_code: 16'h0000,
                rdata: state_next.rdata, rvalid: state_next.rvalid,
                rd_mem: state_next.rd_mem, code: 16'h0000, code_valid: 1'b0
            };
        end
    end

    // State register.
    always_ff @(posedge clk) begin
        if (srst) begin
            state_reg <= ST_RST;
        end else begin
            state_reg <= state_next;
        end
    end

    // Plain configuration bytes go to the byte store.
    assign mem_wr = reg_req.wr && !state_reg.soft_rst && !is_local(reg_req.addr);
    assign mem_rd = reg_req.rd && !is_local(reg_req.addr);

    dpc_cfg_mem u_cfg_mem (
        .clk   (clk),
        .wr_en (mem_wr),
        .addr  (reg_req.addr),
        .wdata (reg_req.wdata),
        .rd_en (mem_rd),
        .rdata (mem_rdata)
    );

    // Outputs taken from the state register and the byte store read data.
    assign reg_rdata = state_reg.rd_mem ? mem_rdata : state_reg.rdata;
    assign reg_rvalid = state_reg.rvalid;
    assign synth_cfg.enable = state_reg.pll_ctl[PLL_EN_BIT];
    assign synth_cfg.vco_output_divider_select = state_reg.vco_div;
    assign synth_cfg.feedback_loop_divide_count = clamp_count(state_reg.loop_cnt);
    assign synth_cfg.reference_divider_select = state_reg.ref_div;
    assign cal_start = state_reg.cal_start;
    assign irq = |(state_reg.irq_stat & state_reg.irq_en);
    assign power_down = state_reg.pwr_dn;
    assign four_wire_mode = (state_reg.spi_cfg & FOUR_WIRE_MASK) == FOUR_WIRE_MASK;
    assign soft_reset_active = state_reg.soft_rst;
    assign inphase_fullscale_gain = state_reg.gain_i;
    assign quadrature_fullscale_gain = state_reg.gain_q;
    assign temp_sensor_enable = state_reg.temp_en;
    assign temp_sample_req = state_reg.temp_req;
    assign code_out = state_reg.code;
    assign code_valid = state_reg.code_valid;

    // Checks on the block's own behaviour.
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    sequence pll_ctl_write;
        reg_req.wr && !state_reg.soft_rst && reg_req.addr == A_PLL_CTL;
    endsequence

    lock_after_cal_a: assert property (state_reg.lock_q |-> state_reg.cal == CAL_DONE)
        else $error("lock shown before calibration valid");
    cal_done_a: assert property (state_reg.cal == CAL_RUN && state_reg.cal_cnt == 16'h0000
        && state_next.pll_ctl[PLL_EN_BIT] && !recal && !state_next.soft_rst
        |=> state_reg.cal == CAL_DONE)
        else $error("calibration valid not reported");
    recal_a: assert property ((pll_ctl_write and reg_req.wdata[PLL_EN_BIT]
        && reg_req.wdata[PLL_RECAL_BIT] && !state_reg.pll_ctl[PLL_RECAL_BIT])
        |=> cal_start && state_reg.cal == CAL_RUN ##1 !cal_start)
        else $error("recalibration did not restart");
    band_upper_a: assert property (state_reg.pll_ctl[PLL_EN_BIT] && band_upper_hit
        && !state_next.soft_rst |=> state_reg.band_hi)
        else $error("upper band edge not flagged");
    lock_irq_a: assert property (!state_reg.lock_q && state_next.lock_q && state_reg.irq_en[1]
        && !state_next.soft_rst |=> irq && state_reg.irq_stat[1])
        else $error("lock event lost");
    irq_clear_a: assert property (reg_req.wr && !state_reg.soft_rst
        && reg_req.addr == A_IRQ_STAT && reg_req.wdata[7] && state_next.lock_q == state_reg.lock_q
        |=> !state_reg.irq_stat[1])
        else $error("interrupt status not cleared");
    count_range_a: assert property (synth_cfg.feedback_loop_divide_count >= LOOP_CNT_MIN
        && synth_cfg.feedback_loop_divide_count <= LOOP_CNT_MAX)
        else $error("loop count out of range");
    gain_low_a: assert property (reg_req.wr && !state_reg.soft_rst
        && reg_req.addr == A_GAIN_I_LO && !state_next.soft_rst
        |=> inphase_fullscale_gain[7:0] == $past(reg_req.wdata))
        else $error("in-phase gain low byte not stored");
    twos_fmt_a: assert property (sample_valid && !state_reg.fmt_bin && !state_next.soft_rst
        |=> code_valid && code_out == ($past(sample_in) ^ SIGN_FLIP))
        else $error("twos complement offset wrong");
    temp_gate_a: assert property (temp_sample_req |-> temp_sensor_enable)
        else $error("sample requested with sensor off");
    soft_rst_a: assert property (reg_req.wr && reg_req.addr == A_SPI_CFG
        && reg_req.wdata == SOFT_RST_CODE |=> soft_reset_active && power_down == POWER_RST)
        else $error("soft reset not entered");
    power_up_a: assert property (reg_req.wr && !state_reg.soft_rst && reg_req.addr == A_POWER
        && reg_req.wdata == 8'h00 |=> power_down == 8'h00)
        else $error("power-up write not applied");

endmodule : dpc_pll_ctrl

//--- verification/dpc_synth_model.sv
/* Behavioural synthesizer core and temperature sensor on the far side.
   Assumes it shares clk with dpc_pll_ctrl and sees its core outputs. */
`timescale 1ns/1ps
module dpc_synth_model
    import dpc_pkg::*;
(
    // Block side.
    input  wire logic           clk,
    input  wire dpc_synth_cfg_t synth_cfg,
    input  wire logic           temp_sample_req,
    // Model answers.
    output logic                pll_lock_detect = 1'b0,
    output logic      [15:0]    temp_result = 16'h0000,
    output logic                temp_result_valid = 1'b0
);
    // result one cycle after the request, scrambled otherwise.
    always @(posedge clk) begin
        pll_lock_detect <= synth_cfg.enable;
        temp_result_valid <= temp_sample_req;
        temp_result <= temp_sample_req ? 16'h1234 : ~temp_result;
    end
endmodule : dpc_synth_model

//--- verification/dpc_pll_ctrl_tb.sv
/* Self-checking bench for dpc_pll_ctrl with its synthesizer model.
   Assumes one 125 MHz clock and register accesses one per cycle. */
`timescale 1ns/1ps
module dpc_pll_ctrl_tb;
    import dpc_pkg::*;
    logic clk = 0, srst = 1, bu = 0, bl = 0, sv = 0, rv, cs, lk, irq, fw, sra, te, ts, tv, cv;
    logic [7:0] rdat, pd;
    logic [9:0] gi, gq;
    logic [15:0] tr, si = 16'h0001, co;
    dpc_reg_req_t rq = '0;
    dpc_synth_cfg_t cfg;
    int fails = 0, checked = 0;
    always #4 clk = ~clk;
    dpc_pll_ctrl u_dpc_pll_ctrl (.clk(clk), .srst(srst), .reg_req(rq), .reg_rdata(rdat),
        .reg_rvalid(rv), .synth_cfg(cfg), .cal_start(cs), .pll_lock_detect(lk),
        .band_upper_hit(bu), .band_lower_hit(bl), .irq(irq), .power_down(pd),
        .four_wire_mode(fw), .soft_reset_active(sra), .inphase_fullscale_gain(gi),
        .quadrature_fullscale_gain(gq), .temp_sensor_enable(te), .temp_sample_req(ts),
        .temp_result(tr), .temp_result_valid(tv), .sample_in(si), .sample_valid(sv),
        .code_out(co), .code_valid(cv));
    dpc_synth_model u_dpc_synth_model (.clk(clk), .synth_cfg(cfg), .temp_sample_req(ts),
        .pll_lock_detect(lk), .temp_result(tr), .temp_result_valid(tv));
    task automatic chk(input logic [16:0] s, input logic [16:0] e, input string n);
        checked++;
        if (s !== e) begin
            fails++;
            $display("BAD %s exp %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic wr(input logic [10:0] a, input logic [7:0] d);
        @(negedge clk) rq = '{a, d, 1'b1, 1'b0};
        @(negedge clk) rq.wr = 1'b0;
    endtask : wr
    task automatic rd(input logic [10:0] a, input logic [7:0] e);
        @(negedge clk) rq = '{a, 8'h00, 1'b0, 1'b1};
        @(negedge clk) rq.rd = 1'b0;
        chk(rv, 1'b1, "rvalid");
        chk(rdat, e, "rdata");
    endtask : rd
    task automatic t_pll();
        wr(A_POWER, 8'h00);
        wr(11'h081, 8'h04);
        wr(11'h284, 8'h62);
        wr(11'h285, 8'hc9);
        wr(11'h08d, 8'h7b);
        wr(11'h1b9, 8'h24);
        rd(11'h1b9, 8'h24);
        wr(A_VCO_DIV, 8'h01);
        chk(cfg.vco_output_divider_select, 2'h1, "vco");
        wr(A_LOOP_CNT, 8'h03);
        chk(cfg.feedback_loop_divide_count, 8'h06, "clamp");
        wr(A_REF_DIV, 8'h04);
        chk(cfg.reference_divider_select, 3'h4, "ref");
        wr(11'h1b6, 8'h4d);
        wr(A_IRQ_EN, 8'hc0);
        wr(A_PLL_CTL, 8'h10);
        chk(cs, 1'b1, "cal_start");
        rd(A_PLL_STAT, 8'h00);
        repeat (205) @(negedge clk);
        rd(A_PLL_STAT, 8'h22);
        chk(irq, 1'b1, "irq");
        rd(A_IRQ_STAT, 8'h80);
        wr(A_IRQ_STAT, 8'h80);
        chk(irq, 1'b0, "irq_clr");
        @(negedge clk) {bu, bl} = 2'b11;
        @(negedge clk) {bu, bl} = 2'b00;
        rd(A_PLL_STAT, 8'he2);
        wr(A_PLL_CTL, 8'h10);
        wr(A_PLL_CTL, 8'h90);
        chk(cs, 1'b1, "recal");
        rd(A_PLL_STAT, 8'h00);
        rd(A_IRQ_STAT, 8'h40);
        $display("done pll");
    endtask : t_pll
    task automatic t_soft();
        wr(A_POWER, 8'h00);
        chk(pd, 8'h00, "power");
        wr(A_SPI_CFG, SOFT_RST_CODE);
        chk(sra, 1'b1, "srst_on");
        wr(A_LOOP_CNT, 8'h20);
        wr(A_SPI_CFG, SOFT_REL_CODE);
        chk({sra, fw}, 2'b01, "release");
        rd(A_LOOP_CNT, LOOP_CNT_RST);
        chk(pd, POWER_RST, "power_rst");
        wr(11'h555, 8'h5a);
        rd(11'h555, 8'h5a);
        $display("done soft");
    endtask : t_soft
    task automatic t_misc();
        wr(A_TEMP_TRIG, 8'h00);
        wr(A_TEMP_TRIG, 8'h01);
        chk(ts, 1'b0, "temp_off");
        wr(A_TEMP_EN, 8'h01);
        wr(A_TEMP_TRIG, 8'h00);
        wr(A_TEMP_TRIG, 8'h01);
        chk(ts, 1'b1, "temp_req");
        repeat (4) @(negedge clk);
        rd(A_TEMP_LO, 8'h34);
        rd(A_TEMP_HI, 8'h12);
        wr(A_GAIN_I_HI, 8'h01);
        wr(A_GAIN_I_LO, 8'haa);
        chk(gi, 10'h1aa, "gain_i");
        wr(A_GAIN_Q_HI, 8'h02);
        chk(gq, 10'h2ff, "gain_q");
        wr(A_GAIN_Q_LO, 8'h55);
        chk(gq, 10'h255, "gain_q_lo");
        @(negedge clk) sv = 1'b1;
        @(negedge clk) chk({cv, co}, 17'h18001, "twos");
        wr(A_DATA_FMT, 8'h01);
        @(negedge clk) chk({cv, co}, 17'h10001, "binary");
        sv = 1'b0;
        @(negedge clk) chk(cv, 1'b0, "code_idle");
        $display("done misc");
    endtask : t_misc
    task automatic complete_run();
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : complete_run
    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        complete_run();
    end
    initial begin
        repeat (10) @(negedge clk);
        srst = 1'b0;
        rd(A_LOOP_CNT, LOOP_CNT_RST);
        t_soft();
        t_pll();
        t_misc();
        complete_run();
    end
endmodule : dpc_pll_ctrl_tb
